// [sbio_pkg.sv]
// Package of constants and decode functions for the six-bit I/O port
package sbio_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned PINS   = 6;

	typedef logic [PINS-1:0] sbio_pins_t;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFS_DATA = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_DIR  = 8'h01;
	localparam logic [ADDR_W-1:0] OFS_ANS  = 8'h02;
	localparam logic [ADDR_W-1:0] OFS_CMP  = 8'h03;

	// ----------------------------------------------------------------
	// Field positions and masks
	// ----------------------------------------------------------------
	localparam int unsigned        PIN_THREE    = 3;
	localparam int unsigned        CMP_OUT_PIN  = 2;
	localparam logic [DATA_W-1:0]  ANS_MASK     = 8'h7f;
	localparam logic [DATA_W-1:0]  CMP_MASK     = 8'h07;
	localparam sbio_pins_t         PIN3_BIT     = 6'h08;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam sbio_pins_t         RST_LATCH = 6'h00;
	localparam sbio_pins_t         RST_DIR   = 6'h3f;
	localparam logic [DATA_W-1:0]  RST_ANS   = 8'h0f;
	localparam logic [2:0]         RST_CMP   = 3'h0;

	// ----------------------------------------------------------------
	// Decode functions
	// ----------------------------------------------------------------
	// Comparator pins in the analog role, pins 1:0 only
	function automatic logic [1:0] cmp_analog(input logic [2:0] mode);
		case (mode)
			3'h5:    cmp_analog = 2'h2;
			3'h6:    cmp_analog = 2'h1;
			3'h7:    cmp_analog = 2'h0;
			default: cmp_analog = 2'h3;
		endcase
	endfunction

	// Comparator output takes over pin 2 in these modes
	function automatic logic cmp_drives(input logic [2:0] mode);
		cmp_drives = (mode == 3'h1) || (mode == 3'h3) || (mode == 3'h6);
	endfunction

	// Pins whose digital input buffer is off
	function automatic sbio_pins_t pin_analog(input logic [3:0] ans,
		input logic [2:0] mode);
		pin_analog = {1'b0, ans[3], 1'b0, ans[2], ans[1:0] | cmp_analog(mode)};
	endfunction

endpackage

// [sbio_port.sv]
// Six-bit general-purpose I/O port with direction, analog and comparator sharing
// ----------------------------------------------------------------------------
// Notes on behaviour
// - Six pins, all but pin three bidirectional, read and written together as one port register.
// - Direction bit 1 makes the pin an input with its driver off.
// - Direction bit 0 drives the output latch value onto the pin.
// - Pin three is input only; its direction bit always reads 1.
// - Port reads return pin levels; port writes go to the output latch.
// - Port writes sample pins, change addressed bits, store all into latch; the latch still stores bit three as 0.
// - With the reset pin enabled, pin three always reads 0.
// - Direction still steers analog pins; software keeps those bits at 1.
// - Pins set as analog inputs read 0 whatever their level.
// - Port bits 7:6 read 0; bits 5:0 show the pin levels.
// - A three-bit comparator mode picks one of eight pin role sets.
// - Digital-output role drives comparator output; normal role is a plain bit.
// - Analog comparator role disables the input buffer and reads 0.
// - An enabled sharing peripheral owns its pin instead of the port.
// ----------------------------------------------------------------------------
//
// Our own choices: the register offsets and the plain strobed port.
module sbio_port
	import sbio_pkg::*;
(
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              srst,
	// Register port
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0] wdata,
	input  wire logic [DATA_W-1:0] wmask,
	input  wire logic              wr_en,
	input  wire logic              rd_en,
	output logic      [DATA_W-1:0] rdata,
	// Configuration and comparator
	input  wire logic              reset_pin_enable_cfg,
	input  wire logic              cmp_out,
	output logic      [2:0]        comparator_mode_field,
	output logic      [3:0]        analog_pin_select,
	// Sharing peripherals
	input  wire logic [PINS-1:0]   periph_en,
	input  wire logic [PINS-1:0]   periph_drv,
	input  wire logic [PINS-1:0]   periph_oe,
	// Pins
	input  wire logic [PINS-1:0]   pin_in,
	output logic      [PINS-1:0]   pin_out,
	output logic      [PINS-1:0]   pin_oe
);

	// ------------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------------
	sbio_pins_t        latch_ff, nxt_latch;
	sbio_pins_t        dir_ff, nxt_dir;
	logic [DATA_W-1:0] ans_ff, nxt_ans;
	logic [2:0]        cmp_ff, nxt_cmp;
	logic [DATA_W-1:0] rdata_ff, nxt_rdata;
	sbio_pins_t        pin_out_ff, nxt_pin_out;
	sbio_pins_t        pin_oe_ff, nxt_pin_oe;

	sbio_pins_t        analog;
	sbio_pins_t        port_read;
	logic              hit_data;
	logic              hit_dir;
	logic              hit_ans;
	logic              hit_cmp;

	// ------------------------------------------------------------------------
	// Address decode and pin view
	// ------------------------------------------------------------------------
	// Decode shared by read and write paths
	assign hit_data = (addr == OFS_DATA);
	assign hit_dir  = (addr == OFS_DIR);
	assign hit_ans  = (addr == OFS_ANS);
	assign hit_cmp  = (addr == OFS_CMP);

	// Input buffer off for analog pins in either select
	assign analog = pin_analog(ans_ff[3:0], cmp_ff);

	// Pin levels as software sees them
	always_comb begin
		port_read = pin_in & ~analog & ~periph_en;
		if (reset_pin_enable_cfg) begin
			port_read[PIN_THREE] = 1'b0;
		end
	end

	// ------------------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------------------
	// Bit-level write enables; unmasked latch bits take the pin levels as read
	always_comb begin
		nxt_latch = latch_ff;
		nxt_dir   = dir_ff;
		nxt_ans   = ans_ff;
		nxt_cmp   = cmp_ff;
		if (wr_en && hit_data) begin
			nxt_latch = (wdata[PINS-1:0] & wmask[PINS-1:0])
				| (port_read & ~wmask[PINS-1:0]);
			nxt_latch[PIN_THREE] = 1'b0;
		end
		if (wr_en && hit_dir) begin
			nxt_dir = (wdata[PINS-1:0] & wmask[PINS-1:0])
				| (dir_ff & ~wmask[PINS-1:0]);
			nxt_dir = nxt_dir | PIN3_BIT;
		end
		if (wr_en && hit_ans) begin
			nxt_ans = ((wdata & wmask) | (ans_ff & ~wmask)) & ANS_MASK;
		end
		if (wr_en && hit_cmp) begin
			nxt_cmp = (wdata[2:0] & wmask[2:0]) | (cmp_ff & ~wmask[2:0]);
		end
	end

	// Register the configuration state
	always_ff @(posedge clk) begin
		if (srst) begin
			latch_ff <= RST_LATCH;
			dir_ff   <= RST_DIR;
			ans_ff   <= RST_ANS;
			cmp_ff   <= RST_CMP;
		end else begin
			latch_ff <= nxt_latch;
			dir_ff   <= nxt_dir;
			ans_ff   <= nxt_ans;
			cmp_ff   <= nxt_cmp;
		end
	end

	// ------------------------------------------------------------------------
	// Register reads
	// ------------------------------------------------------------------------
	// Unmapped addresses read as zero; data appears the cycle after the strobe
	always_comb begin
		nxt_rdata = '0;
		if (rd_en) begin
			case (1'b1)
				hit_data: nxt_rdata = {2'b00, port_read};
				hit_dir:  nxt_rdata = {2'b00, dir_ff | PIN3_BIT};
				hit_ans:  nxt_rdata = ans_ff & ANS_MASK;
				hit_cmp:  nxt_rdata = {5'h00, cmp_ff};
				default:  nxt_rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			rdata_ff <= '0;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	// ------------------------------------------------------------------------
	// Pin drivers
	// ------------------------------------------------------------------------
	// Owner priority: peripheral, then comparator output, then port latch.
	// Direction still gates analog pins, so a cleared bit there will fight
	// the analog source; that is left to software.
	always_comb begin
		nxt_pin_oe  = ~dir_ff;
		nxt_pin_out = latch_ff;
		if (cmp_drives(cmp_ff)) begin
			nxt_pin_out[CMP_OUT_PIN] = cmp_out;
		end
		nxt_pin_out = (periph_drv & periph_en) | (nxt_pin_out & ~periph_en);
		nxt_pin_oe  = (periph_oe & periph_en) | (nxt_pin_oe & ~periph_en);
		nxt_pin_oe[PIN_THREE]  = 1'b0;
		nxt_pin_out[PIN_THREE] = 1'b0;
	end

	// Registered so pins never glitch on decode hazards
	always_ff @(posedge clk) begin
		if (srst) begin
			pin_out_ff <= '0;
			pin_oe_ff  <= '0;
		end else begin
			pin_out_ff <= nxt_pin_out;
			pin_oe_ff  <= nxt_pin_oe;
		end
	end

	// ------------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------------
	assign rdata                 = rdata_ff;
	assign pin_out               = pin_out_ff;
	assign pin_oe                = pin_oe_ff;
	assign comparator_mode_field = cmp_ff;
	assign analog_pin_select     = ans_ff[3:0];

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	sequence s_rd_data;
		rd_en && hit_data;
	endsequence

	sequence s_rd_dir;
		rd_en && hit_dir;
	endsequence

	sequence s_wr_data;
		wr_en && hit_data;
	endsequence

	// Pin three direction reads as one
	dir_pin3_a: assert property (s_rd_dir |=> rdata[3] && rdata[7:6] == 2'b00)
		else $error("pin three direction did not read one");

	// Pin three never driven
	pin3_hiz_a: assert property (!pin_oe[PIN_THREE])
		else $error("pin three output enable raised");

	// Top port bits read zero
	data_top_a: assert property (s_rd_data |=> rdata[7:6] == 2'b00)
		else $error("unimplemented port bits read nonzero");

	// Digital pin reads its level
	data_level_a: assert property (s_rd_data ##0 !periph_en[5]
		|=> rdata[5] == $past(pin_in[5]))
		else $error("port read did not return pin level");

	// Reset pin function hides pin three
	rstpin_read_a: assert property (s_rd_data ##0 reset_pin_enable_cfg
		|=> !rdata[PIN_THREE])
		else $error("pin three read nonzero with reset pin enabled");

	// Analog select reads zero
	analog_read_a: assert property (s_rd_data ##0 ans_ff[3] |=> !rdata[4])
		else $error("analog pin four read nonzero");

	// Comparator analog role reads zero
	cmp_analog_a: assert property (s_rd_data ##0 cmp_ff == 3'h0
		|=> rdata[1:0] == 2'b00)
		else $error("comparator analog pins read nonzero");

	// Input direction releases pin
	input_hiz_a: assert property (dir_ff[0] && !periph_en[0] |=> !pin_oe[0])
		else $error("input pin still driven");

	// Output direction drives latch
	output_drive_a: assert property (!dir_ff[5] && !periph_en[5]
		|=> pin_oe[5] && pin_out[5] == $past(latch_ff[5]))
		else $error("output pin not driving latch");

	// Comparator output takes pin two
	cmp_drive_a: assert property (cmp_ff == 3'h1 && !periph_en[2]
		|=> pin_out[2] == $past(cmp_out))
		else $error("comparator output not on pin two");

	// Unmasked bits take pin levels
	rmw_keep_a: assert property (s_wr_data ##0 !wmask[0]
		|=> latch_ff[0] == $past(port_read[0]))
		else $error("write did not sample pin level");

	// Masked bits take write data
	rmw_set_a: assert property (s_wr_data ##0 wmask[5]
		|=> latch_ff[5] == $past(wdata[5]))
		else $error("write data not stored in latch");

	// Direction of pin three holds
	dir_hold_a: assert property (wr_en && hit_dir |=> dir_ff[PIN_THREE])
		else $error("pin three direction changed");

	// Peripheral owns its pin
	periph_own_a: assert property (periph_en[1]
		|=> pin_oe[1] == $past(periph_oe[1]) && pin_out[1] == $past(periph_drv[1]))
		else $error("peripheral did not own its pin");

	// Mode decode reaches analog mask
	mode_off_a: assert property (cmp_ff == 3'h7 |-> analog[2:0] == {ans_ff[2:0]})
		else $error("comparator off mode still analog");

	// Read data stand one cycle, then fall back to zero
	rdata_idle_a: assert property (!rd_en
		|=> rdata == 8'h00)
		else $error("read data did not return to zero");

	// Reset releases every pin; checked while reset is high, hence no disable
	reset_out_a: assert property (disable iff (1'b0) srst
		|=> pin_oe == 6'h00 && pin_out == 6'h00 && rdata == 8'h00)
		else $error("outputs not quiet after reset");

	// Other digital-output modes also hand pin two to the comparator
	cmp_drive_alt_a: assert property ((cmp_ff == 3'h3 || cmp_ff == 3'h6)
		&& !periph_en[2] |=> pin_out[2] == $past(cmp_out))
		else $error("comparator output missing on pin two");

	// Normal role leaves pin two to its latch
	pin2_latch_a: assert property (!(cmp_ff == 3'h1 || cmp_ff == 3'h3 || cmp_ff == 3'h6)
		&& !periph_en[2] |=> pin_out[2] == $past(latch_ff[2]))
		else $error("pin two not driving its latch");

	// Mode five keeps pin one analog
	mode5_analog_a: assert property (s_rd_data ##0 cmp_ff == 3'h5
		|=> !rdata[1])
		else $error("pin one read nonzero in mode five");

	// Mode six keeps pin zero analog
	mode6_analog_a: assert property (s_rd_data ##0 cmp_ff == 3'h6
		|=> !rdata[0])
		else $error("pin zero read nonzero in mode six");

	// Analog select bit zero hides pin zero
	ans_pin0_a: assert property (s_rd_data ##0 ans_ff[0]
		|=> !rdata[0])
		else $error("analog pin zero read nonzero");

	// Peripheral-owned pin is no port input
	periph_read_a: assert property (s_rd_data ##0 periph_en[5]
		|=> !rdata[5])
		else $error("peripheral pin read as port input");

	// Digital pin zero reads its level
	pin0_level_a: assert property (s_rd_data ##0 !ans_ff[0] && cmp_ff == 3'h7
		&& !periph_en[0] |=> rdata[0] == $past(pin_in[0]))
		else $error("pin zero read did not return level");

	// Analog select bit seven is not stored
	ans_top_a: assert property (rd_en && hit_ans
		|=> !rdata[7])
		else $error("analog select bit seven read nonzero");

	// Comparator control keeps only the mode field
	cmp_read_a: assert property (rd_en && hit_cmp
		|=> rdata[7:3] == 5'h00)
		else $error("comparator control upper bits read nonzero");

	// Unmapped places read as zero
	unmapped_read_a: assert property (rd_en
		&& !(hit_data || hit_dir || hit_ans || hit_cmp) |=> rdata == 8'h00)
		else $error("unmapped place read nonzero");

	// Port latch keeps pin three low
	latch_pin3_a: assert property (s_wr_data
		|=> !latch_ff[PIN_THREE])
		else $error("latch bit three set");

	// Direction bits take written data
	dir_write_a: assert property (wr_en && hit_dir && wmask[5]
		|=> dir_ff[5] == $past(wdata[5]))
		else $error("direction bit five not written");

endmodule

// [sbio_board.sv]
// Board model for the six port pins
module sbio_board
	import sbio_pkg::*;
(
	// Port side
	input  wire logic [PINS-1:0] pin_out,
	input  wire logic [PINS-1:0] pin_oe,
	// Board side
	input  wire logic [PINS-1:0] ext_lvl,
	output logic      [PINS-1:0] pin_lvl
);
	timeunit 1ns;
	timeprecision 100ps;
	// Board drives only released pins, so no contention
	assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule

// [six_bit_io_port_bench.sv]
// Self-checking bench for the six-bit I/O port
module six_bit_io_port_bench
	import sbio_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	// ----------------------------------------------------------------
	// Signals and bench model state
	// ----------------------------------------------------------------
	logic              clk = 1'b0;
	logic              srst = 1'b1;
	logic [ADDR_W-1:0] addr = '0;
	logic [DATA_W-1:0] wdata = '0;
	logic [DATA_W-1:0] wmask = '0;
	logic              wr_en = 1'b0;
	logic              rd_en = 1'b0;
	logic              cfg = 1'b0;
	logic              cmp_out = 1'b0;
	logic [DATA_W-1:0] rdata;
	logic [2:0]        mode_o;
	logic [3:0]        ans_o;
	sbio_pins_t        pen = '0, pdrv = '0, poe = '0, ext = '0, lvl, p_out, p_oe;
	sbio_pins_t        lat = '0, dirv = 6'h3f;
	logic [7:0]        ans = 8'h0f, rv;
	logic [2:0]        mode = '0;
	logic [31:0]       seed = 32'h7384;
	int                err_total = 0, checked = 0;

	sbio_port u_dut (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wmask(wmask),
		.wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .reset_pin_enable_cfg(cfg),
		.cmp_out(cmp_out), .comparator_mode_field(mode_o), .analog_pin_select(ans_o),
		.periph_en(pen), .periph_drv(pdrv), .periph_oe(poe), .pin_in(lvl),
		.pin_out(p_out), .pin_oe(p_oe));
	sbio_board u_board (.pin_out(p_out), .pin_oe(p_oe), .ext_lvl(ext), .pin_lvl(lvl));

	initial begin
		forever #12.5 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// Expectation functions
	// ----------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Pins with the digital input buffer off
	function automatic sbio_pins_t f_ana();
		logic [1:0] c;
		case (mode)
			3'h5: c = 2'h2;
			3'h6: c = 2'h1;
			3'h7: c = 2'h0;
			default: c = 2'h3;
		endcase
		return {1'b0, ans[3], 1'b0, ans[2], ans[1:0] | c};
	endfunction
	function automatic sbio_pins_t f_oe();
		return (pen & poe) | (~pen & ~dirv);
	endfunction
	// Peripheral first, then comparator output on pin 2, then latch
	// Pin 3 is input only, so its drive value stays low even for a peripheral
	function automatic sbio_pins_t f_out();
		sbio_pins_t o;
		o = lat;
		if (mode == 3'h1 || mode == 3'h3 || mode == 3'h6) begin
			o[2] = cmp_out;
		end
		return ((pen & pdrv) | (~pen & o)) & ~PIN3_BIT;
	endfunction
	function automatic sbio_pins_t f_view();
		sbio_pins_t l;
		l = (f_oe() & f_out()) | (~f_oe() & ext);
		return l & ~(f_ana() | pen | (cfg ? PIN3_BIT : 6'h00));
	endfunction

	// ----------------------------------------------------------------
	// Bus, compare and closing tasks
	// ----------------------------------------------------------------
	// Model follows each write; port write samples the settled pin view
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [7:0] m);
		if (a == OFS_DATA) lat = ((d[5:0] & m[5:0]) | (f_view() & ~m[5:0])) & 6'h37;
		if (a == OFS_DIR) dirv = d[5:0] | PIN3_BIT;
		if (a == OFS_ANS) ans = d & ANS_MASK;
		if (a == OFS_CMP) mode = d[2:0];
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wmask <= m;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic chk_reg(input string n, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk_pin(input string n, input sbio_pins_t e, input sbio_pins_t g);
		chk_reg(n, {2'b00, e}, {2'b00, g});
	endtask
	// Lets pins settle, then checks drive and the port read
	task automatic settle();
		repeat (3) @(posedge clk);
		#1 chk_pin("pin_oe", f_oe(), p_oe);
		chk_pin("pin_out", f_out(), p_out);
		rd(OFS_DATA, rv);
		chk_reg("port", {2'b00, f_view()}, rv);
	endtask
	task automatic results();
		$display("checked %0d err_total %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		ext <= 6'h2d;
		// Reset values and an unmapped place
		rd(OFS_DIR, rv);
		chk_reg("dir reset", 8'h3f, rv);
		rd(OFS_ANS, rv);
		chk_reg("ans reset", 8'h0f, rv);
		rd(OFS_CMP, rv);
		chk_reg("cmp reset", 8'h00, rv);
		rd(8'h04, rv);
		chk_reg("unmapped", 8'h00, rv);
		settle();
		// Pins digital before use; pin 3 direction and top bits ignore writes
		wr(OFS_ANS, 8'h00, 8'hff);
		wr(OFS_CMP, 8'h07, 8'hff);
		wr(OFS_DIR, 8'hc0, 8'hff);
		rd(OFS_DIR, rv);
		chk_reg("dir pin3", 8'h08, rv);
		// Random direction and masked port writes
		repeat (12) begin
			seed = lfsr(seed);
			@(posedge clk) ext <= seed[13:8];
			wr(OFS_DIR, seed[7:0], 8'hff);
			settle();
			wr(OFS_DATA, seed[23:16], seed[31:24]);
			settle();
		end
		// Every comparator mode; no comparator interrupt here
		for (int m = 0; m < 8; m++) begin
			seed = lfsr(seed);
			@(posedge clk) cmp_out <= seed[0];
			wr(OFS_CMP, {seed[15:11], m[2:0]}, 8'hff);
			wr(OFS_DIR, {2'b00, f_ana()}, 8'hff);
			rd(OFS_CMP, rv);
			chk_reg("cmp", {5'b0_0000, m[2:0]}, rv);
			chk_reg("mode out", {5'b0_0000, m[2:0]}, {5'b0_0000, mode_o});
			settle();
		end
		// Analog select, reset pin option and sharing peripherals
		wr(OFS_CMP, 8'h07, 8'hff);
		repeat (8) begin
			seed = lfsr(seed);
			@(posedge clk);
			cfg <= seed[0];
			pen <= seed[6:1];
			pdrv <= seed[12:7];
			poe <= seed[18:13] & 6'h37;
			wr(OFS_ANS, seed[31:24], 8'hff);
			wr(OFS_DIR, {2'b00, seed[24:19] | f_ana()}, 8'hff);
			rd(OFS_ANS, rv);
			chk_reg("ans", ans, rv);
			chk_reg("ans out", {4'h0, ans[3:0]}, {4'h0, ans_o});
			settle();
		end
		results();
	end

	// Watchdog, far beyond the roughly 400 cycles the run needs
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		results();
	end
endmodule
